// File: rtl/lsdc_pkg.sv
package lsdc_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int XTAL_HZ = 32768;
	localparam int NWORD = 19;
	localparam int NSEG = 2 * NWORD;
	localparam int NPIN = 8;
	localparam logic [13:0] IDX_SYNC = 14'h2020;
	localparam logic [13:0] IDX_CTRL = 14'h2021;
	localparam logic [13:0] IDX_PINMAP = 14'h2023;
	localparam logic [13:0] IDX_BLINK = 14'h205A;
	localparam logic [13:0] IDX_POWER = 14'h20A9;
	localparam logic [13:0] IDX_DAC = 14'h20AB;
	localparam logic [13:0] IDX_STATUS = 14'h20B8;
	localparam logic [13:0] SEG_IDX [NWORD] = '{
		14'h2030, 14'h2031, 14'h2035, 14'h2037, 14'h2038,
		14'h2039, 14'h2041, 14'h2042, 14'h2043, 14'h2044,
		14'h2045, 14'h2047, 14'h2048, 14'h2049, 14'h204D,
		14'h204E, 14'h204F, 14'h2051, 14'h2059};
	localparam logic [4:0] SLOT_NONE = 5'h1F;
	localparam int BLINK_SLOT = 7;
	localparam int SYNC_POS = 7;
	localparam int ONLY_POS = 5;
	localparam int DAC_LSB = 1;
	localparam int STEP_MV = 200;
	localparam int BLINK_FAST_MS = 500;
	localparam int BLINK_SLOW_MS = 1000;
	localparam int BLINK_FAST_TK = BLINK_FAST_MS * XTAL_HZ / 1000;
	localparam int BLINK_SLOW_TK = BLINK_SLOW_MS * XTAL_HZ / 1000;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_V1 = 2'h1;
	localparam logic [1:0] LVL_V2 = 2'h2;
	localparam logic [1:0] LVL_V3 = 2'h3;

	typedef enum logic [2:0] {
		BIAS_4_THIRD = 3'h0,
		BIAS_3_THIRD = 3'h1,
		BIAS_2_HALF = 3'h2,
		BIAS_3_HALF = 3'h3,
		BIAS_STATIC = 3'h4
	} lsdc_bias_t;

	typedef struct packed {
		logic reserved;
		logic blink_slow;
		logic enable;
		logic [2:0] bias;
		logic [1:0] rate;
	} lsdc_ctrl_t;

	typedef struct packed {
		logic sys_power;
		logic autowake;
		logic push_button;
		logic adc_sync;
	} lsdc_wake_t;
endpackage : lsdc_pkg

// File: rtl/lsdc_top.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module lsdc_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire lsdc_pkg::lsdc_wake_t wake_in,
	output logic display_only_mode,
	output logic [2:0] bias_rail_en,
	output logic [2:0] drive_voltage_code,
	output logic [10:0] supply_drop_mv,
	output logic [3:0][1:0] com_level,
	output logic [lsdc_pkg::NSEG-1:0][1:0] seg_level,
	output logic [1:0] segment_pin_7,
	output logic [lsdc_pkg::NPIN-1:0] pin_is_lcd,
	output logic [lsdc_pkg::NPIN-1:0] dio_out
);
	import lsdc_pkg::*;

	// Word slot for a register index, or none
	function automatic logic [4:0] seg_slot(input logic [13:0] idx);
		logic [4:0] s;
		s = SLOT_NONE;
		for (int i = 0; i < NWORD; i++) begin
			if (SEG_IDX[i] == idx) begin
				s = 5'(i);
			end
		end
		return s;
	endfunction : seg_slot

	// Common level; a selected common swings by polarity
	function automatic logic [1:0] com_lvl(input logic sel,
		input logic pol, input logic half);
		if (sel) begin
			return pol ? LVL_V3 : LVL_GND;
		end else if (half) begin
			return LVL_V1;
		end else begin
			return pol ? LVL_V1 : LVL_V2;
		end
	endfunction : com_lvl

	// Segment level; a lit segment takes the opposite rail
	function automatic logic [1:0] seg_lvl(input logic on,
		input logic pol, input logic half);
		if (on) begin
			return pol ? LVL_GND : LVL_V3;
		end else if (half) begin
			return pol ? LVL_V3 : LVL_GND;
		end else begin
			return pol ? LVL_V2 : LVL_V1;
		end
	endfunction : seg_lvl

	// Commons in use for each bias mode
	function automatic logic [2:0] com_count(input logic [2:0] mode);
		case (mode)
			BIAS_4_THIRD: return 3'h4;
			BIAS_3_THIRD: return 3'h3;
			BIAS_2_HALF: return 3'h2;
			BIAS_3_HALF: return 3'h3;
			BIAS_STATIC: return 3'h1;
			default: return 3'h4;
		endcase
	endfunction : com_count

	// Register file
	lsdc_ctrl_t ctrl;
	logic [7:0] sync_reg;
	logic [7:0] pin_map;
	logic [3:0] blink_map;
	logic [2:0] dac_code;
	logic [7:0] seg_mem [NWORD];
	logic sleep;

	// Bus address phase capture
	logic ap_valid;
	logic ap_write;
	logic ap_hi_ok;
	logic [13:0] ap_idx;
	logic rd_done;
	logic rd_busy;
	logic wr_go;
	logic [4:0] wr_slot;
	logic [4:0] rd_slot;

	// Timing and drive state
	logic [31:0] xtal_acc;
	logic xtal_tick;
	logic [7:0] rate_cnt;
	logic [7:0] rate_max;
	logic drive_tick;
	logic [1:0] com_idx;
	logic pol;
	logic [15:0] blink_cnt;
	logic blink_on;
	logic half;

	// Reads insert one wait state so a preceding write is always seen
	assign rd_busy = ap_valid && !ap_write && !rd_done;
	assign hreadyout = !rd_busy;
	assign hresp = 1'b0;
	assign wr_go = ap_valid && ap_write && ap_hi_ok;
	assign wr_slot = seg_slot(ap_idx);
	assign rd_slot = wr_slot;

	// Address phase held while a read waits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_hi_ok <= 1'b0;
			ap_idx <= 14'h0000;
		end else if (hready) begin
			ap_valid <= hsel && htrans[1];
			ap_write <= hwrite;
			ap_hi_ok <= haddr[31:16] == 16'h0000;
			ap_idx <= haddr[15:2];
		end
	end

	// Read data captured in the wait state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_done <= 1'b0;
			hrdata <= 32'h00000000;
		end else if (rd_busy) begin
			rd_done <= 1'b1;
			hrdata <= 32'h00000000;
			// Outside the block's window reads zero
			if (ap_hi_ok) begin
				if (rd_slot != SLOT_NONE) begin
					hrdata[7:0] <= seg_mem[rd_slot];
				end
				case (ap_idx)
					IDX_SYNC: hrdata[7:0] <= sync_reg;
					IDX_CTRL: hrdata[7:0] <= ctrl;
					IDX_PINMAP: hrdata[7:0] <= pin_map;
					IDX_BLINK: hrdata[3:0] <= blink_map;
					IDX_POWER: hrdata[ONLY_POS] <= sleep;
					IDX_DAC: hrdata[DAC_LSB+:3] <= dac_code;
					IDX_STATUS: hrdata[4:0] <=
						{sleep, wake_in.sys_power, com_idx, pol};
					default: ;
				endcase
			end
		end else if (hready) begin
			rd_done <= 1'b0;
		end
	end

	// Control registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl <= REG_RESET;
			sync_reg <= REG_RESET;
			pin_map <= REG_RESET;
			blink_map <= REG_RESET[3:0];
			dac_code <= REG_RESET[2:0];
		end else if (wr_go) begin
			case (ap_idx)
				IDX_SYNC: sync_reg <= hwdata[7:0];
				IDX_CTRL: ctrl <= {1'b0, hwdata[6:0]};
				IDX_PINMAP: pin_map <= hwdata[7:0];
				IDX_BLINK: blink_map <= hwdata[3:0];
				IDX_DAC: dac_code <= hwdata[DAC_LSB+:3];
				default: ;
			endcase
		end
	end

	// Segment words; software merges bytes itself
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < NWORD; i++) begin
				seg_mem[i] <= REG_RESET;
			end
		end else if (wr_go && wr_slot != SLOT_NONE) begin
			seg_mem[wr_slot] <= hwdata[7:0];
		end
	end

	// Display-only sleep; any wake source beats a same-cycle request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sleep <= 1'b0;
		end else if (wake_in.sys_power || wake_in.autowake ||
			wake_in.push_button) begin
			sleep <= 1'b0;
		end else if (wr_go && ap_idx == IDX_POWER &&
			hwdata[ONLY_POS]) begin
			sleep <= 1'b1;
		end
	end

	// 32768 Hz tick from the system clock by fractional accumulation
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			xtal_acc <= 32'h00000000;
			xtal_tick <= 1'b0;
		end else if (xtal_acc + 32'(XTAL_HZ) >= 32'(CLK_HZ)) begin
			xtal_acc <= xtal_acc + 32'(XTAL_HZ) - 32'(CLK_HZ);
			xtal_tick <= 1'b1;
		end else begin
			xtal_acc <= xtal_acc + 32'(XTAL_HZ);
			xtal_tick <= 1'b0;
		end
	end

	// Crystal ticks per drive step, less one
	always_comb begin
		case (ctrl.rate)
			2'h1: rate_max = 8'hFF;
			2'h2: rate_max = 8'h7F;
			2'h3: rate_max = 8'h3F;
			default: rate_max = 8'h00;
		endcase
	end

	// Rate code 0 freezes the common walk
	assign drive_tick = xtal_tick && ctrl.rate != 2'h0 &&
		rate_cnt >= rate_max;

	// Cleared while disabled so a restart is clean
	always_ff @(posedge clk_sys) begin
		if (rst || !ctrl.enable) begin
			rate_cnt <= 8'h00;
		end else if (xtal_tick) begin
			rate_cnt <= drive_tick ? 8'h00 : rate_cnt + 8'h01;
		end
	end

	// Time division walk; polarity flips after each full frame
	always_ff @(posedge clk_sys) begin
		if (rst || !ctrl.enable) begin
			com_idx <= 2'h0;
			pol <= 1'b0;
		end else if (drive_tick) begin
			if (3'(com_idx) + 3'h1 >= com_count(ctrl.bias)) begin
				com_idx <= 2'h0;
				pol <= !pol;
			end else begin
				com_idx <= com_idx + 2'h1;
			end
		end
	end

	// Blink phase toggles each half period
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			blink_cnt <= 16'h0000;
			blink_on <= 1'b1;
		end else if (xtal_tick) begin
			if (32'(blink_cnt) + 32'h1 >= (ctrl.blink_slow ?
				32'(BLINK_SLOW_TK) : 32'(BLINK_FAST_TK))) begin
				blink_cnt <= 16'h0000;
				blink_on <= !blink_on;
			end else begin
				blink_cnt <= blink_cnt + 16'h0001;
			end
		end
	end

	// Half bias keeps unselected commons mid-rail
	assign half = ctrl.bias == BIAS_2_HALF || ctrl.bias == BIAS_3_HALF;

	// Drive levels
	always_ff @(posedge clk_sys) begin
		if (rst || !ctrl.enable) begin
			com_level <= '0;
			seg_level <= '0;
			bias_rail_en <= 3'h0;
		end else begin
			bias_rail_en <= 3'h7;
			// Unused commons stay at ground
			for (int c = 0; c < 4; c++) begin
				com_level[c] <= (3'(c) < com_count(ctrl.bias)) ?
					com_lvl(com_idx == 2'(c) ||
					ctrl.bias == BIAS_STATIC, pol, half) :
					LVL_GND;
			end
			// Blinking masks one slot's low nibble only
			for (int n = 0; n < NWORD; n++) begin
				seg_level[n] <= seg_lvl(seg_mem[n][com_idx] &&
					(n != BLINK_SLOT || blink_on ||
					!blink_map[com_idx]), pol, half);
				seg_level[NWORD+n] <= seg_lvl(
					seg_mem[n][4+com_idx], pol, half);
			end
		end
	end

	// Segment pin 7 doubles as the sync output
	always_ff @(posedge clk_sys) begin
		if (rst || !ctrl.enable) begin
			segment_pin_7 <= LVL_GND;
		end else if (sync_reg[SYNC_POS]) begin
			segment_pin_7 <= wake_in.adc_sync ? LVL_V3 : LVL_GND;
		end else begin
			segment_pin_7 <= seg_lvl(sync_reg[com_idx], pol, half);
		end
	end

	// Pin function, supply code and mode outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_is_lcd <= '0;
			dio_out <= '0;
			drive_voltage_code <= 3'h0;
			supply_drop_mv <= 11'h000;
			display_only_mode <= 1'b0;
		end else begin
			pin_is_lcd <= pin_map;
			// DIO pins show bit 0 of their word
			for (int p = 0; p < NPIN; p++) begin
				dio_out[p] <= !pin_map[p] && seg_mem[p][0];
			end
			drive_voltage_code <= dac_code;
			supply_drop_mv <= 11'(32'(dac_code) * STEP_MV);
			display_only_mode <= sleep;
		end
	end
endmodule : lsdc_top

// File: tb/lsdc_checker.sv
`timescale 1ns/1ps
module lsdc_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire lsdc_pkg::lsdc_wake_t wake_in,
	input wire logic display_only_mode,
	input wire logic [2:0] bias_rail_en,
	input wire logic [2:0] drive_voltage_code,
	input wire logic [10:0] supply_drop_mv,
	input wire logic [3:0][1:0] com_level,
	input wire logic [lsdc_pkg::NSEG-1:0][1:0] seg_level
);
	import lsdc_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_req;
		hsel && hready && htrans[1];
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_one_wait: assert property (s_req ##0 !hwrite |=> s_one_wait)
		else $error("read data phase not one wait");
	a_write_no_wait: assert property (s_req ##0 hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_drop_per_step: assert property (
		supply_drop_mv == 11'(drive_voltage_code * STEP_MV))
		else $error("supply drop not code times step");
	a_rails_all_none: assert property (
		bias_rail_en == 3'h0 || bias_rail_en == 3'h7)
		else $error("bias rails partly on");
	a_off_outputs_gnd: assert property (
		(bias_rail_en == 3'h0) [*2] |->
		com_level == '0 && seg_level == '0)
		else $error("outputs not grounded while off");
	a_power_blocks_sleep: assert property (
		wake_in.sys_power |-> ##2 !display_only_mode)
		else $error("sleep held on main power");
	a_wake_sources: assert property (
		wake_in.push_button || wake_in.autowake |-> ##2 !display_only_mode)
		else $error("no wake on button or timer");
	a_reset_clears: assert property (
		$fell(rst) |-> !display_only_mode && bias_rail_en == 3'h0 && com_level == '0)
		else $error("outputs not clear after reset");
endmodule : lsdc_checker

bind lsdc_top lsdc_checker u_checker (.clk_sys(clk_sys), .rst(rst),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .wake_in(wake_in),
	.display_only_mode(display_only_mode), .bias_rail_en(bias_rail_en),
	.drive_voltage_code(drive_voltage_code),
	.supply_drop_mv(supply_drop_mv), .com_level(com_level),
	.seg_level(seg_level));

// File: tb/lsdc_glass_model.sv
`timescale 1ns/1ps
module lsdc_glass_model (
	input wire logic [3:0][1:0] com_level,
	input wire logic [lsdc_pkg::NSEG-1:0][1:0] seg_level,
	output logic [lsdc_pkg::NSEG-1:0] seg_on
);
	import lsdc_pkg::*;
	// A pixel darkens only under the full span against some common
	always_comb begin
		for (int n = 0; n < NSEG; n++) begin
			seg_on[n] = 1'b0;
			for (int k = 0; k < 4; k++) begin
				if ({com_level[k], seg_level[n]} inside {4'hC, 4'h3}) begin
					seg_on[n] = 1'b1;
				end
			end
		end
	end
endmodule : lsdc_glass_model

// File: tb/lcd_segment_driver_control_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module lcd_segment_driver_control_tb;
	import lsdc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hrdy, hresp, sleep;
	lsdc_wake_t wake_in = '0;
	logic [2:0] rails, dac;
	logic [10:0] drop;
	logic [3:0][1:0] com;
	logic [NSEG-1:0][1:0] seg;
	logic [1:0] pin7;
	logic [NPIN-1:0] lcd_pins, dio;
	logic [NSEG-1:0] seg_on;
	int errors = 0, checks = 0, cycles = 0;
	int ncom [5] = '{4, 3, 2, 3, 1};

	lsdc_top dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdy),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.wake_in(wake_in), .display_only_mode(sleep), .bias_rail_en(rails),
		.drive_voltage_code(dac), .supply_drop_mv(drop), .com_level(com),
		.seg_level(seg), .segment_pin_7(pin7), .pin_is_lcd(lcd_pins),
		.dio_out(dio));
	lsdc_glass_model glass (.com_level(com), .seg_level(seg),
		.seg_on(seg_on));

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic xfer(input logic w, input logic [13:0] idx,
		input logic [7:0] wd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {16'h0000, idx, 2'h0};
		do @(posedge clk_sys); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		do @(posedge clk_sys); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask : xfer

	task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		`CHK(rd, {24'h000000, exp})
		`CHK(hresp, 1'b0)
	endtask : rd_chk

	task automatic settle;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : settle

	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < NWORD; i++) rd_chk(SEG_IDX[i], 8'h00);
		rd_chk(IDX_CTRL, 8'h00);
		for (int i = 0; i < NWORD; i++) xfer(1'b1, SEG_IDX[i], 8'(i * 13 + 5));
		for (int i = 0; i < NWORD; i++) rd_chk(SEG_IDX[i], 8'(i * 13 + 5));
		// Unmapped place ignores writes; top control bit reads zero
		xfer(1'b1, 14'h2022, 8'hA5);
		rd_chk(14'h2022, 8'h00);
		xfer(1'b1, IDX_CTRL, 8'hFF);
		rd_chk(IDX_CTRL, 8'h7F);
		xfer(1'b1, IDX_BLINK, 8'hFF);
		rd_chk(IDX_BLINK, 8'h0F);
		xfer(1'b0, IDX_SYNC, 8'h00);
		xfer(1'b1, IDX_SYNC, rd[7:0] | 8'h80);
		wake_in.adc_sync <= 1'b1;
		settle();
		`CHK(pin7, 2'h3)
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, IDX_DAC, 8'(c << 1));
			settle();
			`CHK(dac, 3'(c))
			`CHK(drop, 11'(c * 200))
		end
		rd_chk(IDX_DAC, 8'h0E);
		xfer(1'b1, IDX_PINMAP, 8'h5A);
		settle();
		`CHK(lcd_pins, 8'h5A)
		`CHK(dio, 8'h05)
		rd_chk(IDX_PINMAP, 8'h5A);
		for (int m = 0; m < 5; m++) begin
			xfer(1'b1, IDX_CTRL, 8'(8'h20 | (m << 2)));
			settle();
			`CHK(rails, 3'h7)
			for (int k = ncom[m]; k < 4; k++) `CHK(com[k], 2'h0)
			if (ncom[m] > 1) `CHK((com[1] != 2'h0), 1'b1)
		end
		// Drive rate frozen, so common 0 stays selected
		xfer(1'b1, IDX_CTRL, 8'h20);
		xfer(1'b1, SEG_IDX[0], 8'h01);
		settle();
		`CHK({seg_on[NWORD], seg_on[0]}, 2'b01)
		xfer(1'b1, SEG_IDX[0], 8'h12);
		settle();
		`CHK({seg_on[NWORD], seg_on[0]}, 2'b10)
		// Sync bit clear: pin 7 is an unlit segment again
		xfer(1'b1, IDX_SYNC, 8'h00);
		settle();
		`CHK(pin7, 2'h1)
		xfer(1'b1, IDX_CTRL, 8'h00);
		xfer(1'b1, IDX_SYNC, 8'h00);
		settle();
		`CHK(rails, 3'h0)
		`CHK(com, 8'h00)
		`CHK(pin7, 2'h0)
		@(posedge clk_sys);
		wake_in <= 4'h8;
		xfer(1'b1, IDX_POWER, 8'h20);
		settle();
		`CHK(sleep, 1'b0)
		for (int s = 1; s < 4; s++) begin
			@(posedge clk_sys);
			wake_in <= 4'h0;
			xfer(1'b1, IDX_POWER, 8'h20);
			settle();
			`CHK(sleep, 1'b1)
			rd_chk(IDX_POWER, 8'h20);
			rd_chk(IDX_STATUS, 8'h10);
			wake_in <= 4'(1 << s);
			settle();
			`CHK(sleep, 1'b0)
		end
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk(SEG_IDX[0], 8'h00);
		report_and_stop();
	end
endmodule : lcd_segment_driver_control_tb
